/* rtl/pia_regs.vh */
// Constants for the peripheral interrupt aggregator.
// Assumes a single system clock domain; included by bare name.
// Summary of operation
// - Motor trip pulse sets the motor protect request flag.
// - Motor vector needs global enable, its enable, stack not full.
// - Motor service clears its flag and the global enable.
// - Group flag sets whenever any member source flag becomes set.
// - Group vector needs global, group enable, stack room, pending source.
// - Group service clears group flag and global enable, not sources.
// - Limit request raised per upper/lower trigger enables versus bounds.
// - Conversion end sets done flag; compare result sets limit flag.
// - Converter vector needs global, group and matching source enable.
// - Converter flags are never cleared by service; software clears.
// - Capture overflow and compare set their flags, grouped.
// - Capture service clears only group flag and global enable.
// - One period and three duty match requests, all in group 2.
// - PWM vector needs global, individual and group 2 enables.
// - PWM service clears group 2 flag and global enable only.
// - Each timer has comparator P and A flags with enables.
// - Timer vector needs global, own, group enable and stack room.
// - Timer service clears only group flag and global enable.
// - Tick divider overflow sets the tick request flag.
// - Tick vector needs global enable, tick enable, stack room.
// - Tick service clears tick flag and global enable.
// - Prescaler source is system clock, quarter, or sub clock.
// - Source select 00 sys, 01 sys/4, 1x sub; resets 00.
// - Period select gives 2^8 to 2^15 prescaled cycles.
// - Any request flag rising wakes the device regardless of enable.
`ifndef PIA_REGS_VH
`define PIA_REGS_VH
`define PIA_SRC_SYS 2'h0
`define PIA_SRC_QUARTER 2'h1
`define PIA_SRC_SEL_RST 2'h0
`define PIA_TICK_SEL_RST 3'h0
`define PIA_TICK_EXP_BASE 8
`define PIA_VEC_NONE 3'h0
`define PIA_VEC_MOTOR 3'h1
`define PIA_VEC_GRP0 3'h2
`define PIA_VEC_GRP1 3'h3
`define PIA_VEC_GRP2 3'h4
`define PIA_VEC_GRP3 3'h5
`define PIA_VEC_TICK 3'h6
`endif

/* rtl/pia_tick_gen.v */
// Time base: prescaler source select and overflow divider.
// Assumes sub clock tick input already synchronised to clk_i.
`timescale 1ns/100ps
`include "pia_regs.vh"
module pia_tick_gen
(
  input wire clk_i,            // System clock
  input wire rst_n_i,          // Async reset, active low
  input wire tick_on_i,        // Time base enable
  input wire [1:0] src_sel_i,  // Prescaler source select
  input wire [2:0] period_i,   // Period select
  input wire sub_tick_i,       // Synchronised sub clock edge pulse
  output reg tick_o            // One-cycle overflow pulse
);
  reg [1:0] quarter_q;
  reg [14:0] div_q;
  reg psc_en;
  wire [14:0] last;

  // ------------------------------------------------------------
  // Prescaled clock enable
  // ------------------------------------------------------------
  // source mux
  always @*
  begin
    if (src_sel_i == `PIA_SRC_SYS)
      psc_en = 1'b1;
    else if (src_sel_i == `PIA_SRC_QUARTER)
      psc_en = (quarter_q == 2'h3);
    else
      psc_en = sub_tick_i;
  end

  assign last = (15'h0100 << period_i) - 15'h0001;

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      quarter_q <= 2'h0;
      div_q <= 15'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      quarter_q <= quarter_q + 2'h1;
      tick_o <= 1'b0;
      if (!tick_on_i)
        div_q <= 15'h0000;
      else if (psc_en)
      begin
        if (div_q >= last)
        begin
          div_q <= 15'h0000;
          tick_o <= 1'b1;
        end
        else
          div_q <= div_q + 15'h0001;
      end
    end
  end
endmodule

/* rtl/pia_top.v */
// Peripheral interrupt aggregator top.
// Assumes event inputs are one-cycle pulses on clk_i, except the sub
// clock, which is an asynchronous pin.
`timescale 1ns/100ps
`include "pia_regs.vh"
module pia_top
#(
  parameter NUM_TMR = 2  // Periodic timers
)
(
  input wire clk_i,                       // System clock
  input wire rst_n_i,                     // Async reset, active low
  input wire motor_protect_trip_i,        // Motor trip pulse
  input wire conv_done_i,                 // Conversion end pulse
  input wire conv_result_valid_i,         // Compare result pulse
  input wire [11:0] conv_result_pair_i,   // Converted value
  input wire [11:0] upper_bound_pair_i,   // Upper boundary
  input wire [11:0] lower_bound_pair_i,   // Lower boundary
  input wire upper_limit_trig_en_i,       // Trigger above upper
  input wire lower_limit_trig_en_i,       // Trigger below lower
  input wire capture_overflow_irq_i,      // Capture overflow pulse
  input wire capture_compare_irq_i,       // Capture compare pulse
  input wire period_match_i,              // PWM period match pulse
  input wire [2:0] duty_match_i,          // PWM duty match pulses
  input wire [NUM_TMR-1:0] timer_cmp_p_i, // Timer comparator P pulses
  input wire [NUM_TMR-1:0] timer_cmp_a_i, // Timer comparator A pulses
  input wire sub_clk_i,                   // Sub clock pin
  input wire global_irq_en_set_i,         // Software sets global enable
  input wire global_irq_en_clr_i,         // Software clears global enable
  input wire motor_protect_irq_en_i,      // Motor enable
  input wire [3:0] group_irq_en_i,        // Group enables
  input wire conv_done_irq_en_i,          // Done enable
  input wire conv_limit_irq_en_i,         // Limit enable
  input wire capture_overflow_en_i,       // Capture overflow enable
  input wire capture_compare_en_i,        // Capture compare enable
  input wire period_match_irq_en_i,       // Period enable
  input wire [2:0] duty_match_irq_en_i,   // Duty enables
  input wire [NUM_TMR-1:0] timer_cmp_p_irq_en_i, // Timer P enables
  input wire [NUM_TMR-1:0] timer_cmp_a_irq_en_i, // Timer A enables
  input wire tick_irq_en_i,               // Tick enable
  input wire tick_on_i,                   // Time base run
  input wire [2:0] tick_period_sel_i,     // Tick period select
  input wire [1:0] prescale_src_sel_i,    // Prescaler source select
  input wire [10:0] flag_clr_i,           // Software clear of source flags
  input wire [NUM_TMR-1:0] timer_cmp_p_clr_i, // Clear timer P flags
  input wire [NUM_TMR-1:0] timer_cmp_a_clr_i, // Clear timer A flags
  input wire stack_full_i,                // Core stack full
  input wire vec_ack_i,                   // Core accepts vector
  output reg irq_req_o,                   // Vector request
  output reg [2:0] irq_vec_o,             // Vector selected
  output reg global_irq_en_o,             // Global enable
  output reg motor_protect_req_flag_o,    // Motor flag
  output reg [3:0] group_req_flag_o,      // Group flags
  output reg [10:0] src_flag_o,           // Source flags
  output reg [NUM_TMR-1:0] timer_cmp_p_flag_o, // Timer P flags
  output reg [NUM_TMR-1:0] timer_cmp_a_flag_o, // Timer A flags
  output reg tick_req_flag_o,             // Tick flag
  output reg wake_o                       // Wake pulse
);
  // Source flag bits: 0 done,1 limit,2 cap ovf,3 cap cmp,4 period,5-7 duty
  // Groups: 0 converter, 1 capture, 2 PWM, 3 timers
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg sub_m_q;
  reg sub_s_q;
  reg sub_d_q;
  reg [1:0] state_q;
  reg [2:0] vec_d;
  reg conv_limit_hit;
  reg [10:0] src_set;
  reg [3:0] grp_pend;
  reg [3:0] grp_set;
  reg [3:0] grp_clr;
  reg [10:0] src_flag_d;
  reg [NUM_TMR-1:0] tmr_p_flag_d;
  reg [NUM_TMR-1:0] tmr_a_flag_d;
  reg [3:0] grp_flag_d;
  reg motor_flag_d;
  reg tick_flag_d;
  wire [4+NUM_TMR*2+13-1:0] all_now;
  wire [4+NUM_TMR*2+13-1:0] all_d;
  wire tick_pulse;
  wire sub_tick;
  wire take;
  wire [10:0] src_en;

  // ------------------------------------------------------------
  // Sub clock synchroniser
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_m_q <= 1'b0;
      sub_s_q <= 1'b0;
      sub_d_q <= 1'b0;
    end
    else
    begin
      sub_m_q <= sub_clk_i;
      sub_s_q <= sub_m_q;
      sub_d_q <= sub_s_q;
    end
  end
  assign sub_tick = sub_s_q & ~sub_d_q;

  pia_tick_gen u_tick
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_on_i(tick_on_i),
    .src_sel_i(prescale_src_sel_i),
    .period_i(tick_period_sel_i),
    .sub_tick_i(sub_tick),
    .tick_o(tick_pulse)
  );

  // ------------------------------------------------------------
  // Source event decode
  // ------------------------------------------------------------
  always @*
  begin
    conv_limit_hit = conv_result_valid_i &
      ((upper_limit_trig_en_i & (conv_result_pair_i > upper_bound_pair_i)) |
       (lower_limit_trig_en_i & (conv_result_pair_i < lower_bound_pair_i)));
    src_set = {3'h0, duty_match_i, period_match_i, capture_compare_irq_i,
               capture_overflow_irq_i, conv_limit_hit, conv_done_i};
  end

  assign src_en = {3'h0, duty_match_irq_en_i, period_match_irq_en_i,
                   capture_compare_en_i, capture_overflow_en_i,
                   conv_limit_irq_en_i, conv_done_irq_en_i};

  // ------------------------------------------------------------
  // Group pending and set terms
  // ------------------------------------------------------------
  always @*
  begin
    grp_pend[0] = |(src_flag_o[1:0] & src_en[1:0]);
    grp_pend[1] = |(src_flag_o[3:2] & src_en[3:2]);
    grp_pend[2] = |(src_flag_o[7:4] & src_en[7:4]);
    grp_pend[3] = |(timer_cmp_p_flag_o & timer_cmp_p_irq_en_i) |
                  |(timer_cmp_a_flag_o & timer_cmp_a_irq_en_i);
    grp_set[0] = |src_set[1:0];
    grp_set[1] = |src_set[3:2];
    grp_set[2] = |src_set[7:4];
    grp_set[3] = |timer_cmp_p_i | |timer_cmp_a_i;
  end

  // ------------------------------------------------------------
  // Priority select
  // ------------------------------------------------------------
  always @*
  begin
    vec_d = `PIA_VEC_NONE;
    if (!global_irq_en_o || stack_full_i)
      vec_d = `PIA_VEC_NONE;
    else if (motor_protect_req_flag_o && motor_protect_irq_en_i)
      vec_d = `PIA_VEC_MOTOR;
    else if (group_req_flag_o[0] && group_irq_en_i[0] && grp_pend[0])
      vec_d = `PIA_VEC_GRP0;
    else if (group_req_flag_o[1] && group_irq_en_i[1] && grp_pend[1])
      vec_d = `PIA_VEC_GRP1;
    else if (group_req_flag_o[2] && group_irq_en_i[2] && grp_pend[2])
      vec_d = `PIA_VEC_GRP2;
    else if (group_req_flag_o[3] && group_irq_en_i[3] && grp_pend[3])
      vec_d = `PIA_VEC_GRP3;
    else if (tick_req_flag_o && tick_irq_en_i)
      vec_d = `PIA_VEC_TICK;
  end

  assign take = vec_ack_i & irq_req_o;

  // Service of one vector code in the acceptance cycle
  function pia_svc_of;
    input hit;
    input [2:0] vec;
    input [2:0] code;
    begin
      pia_svc_of = hit && (vec == code);
    end
  endfunction

  always @*
  begin
    grp_clr = 4'h0;
    if (pia_svc_of(take, irq_vec_o, `PIA_VEC_GRP0))
      grp_clr[0] = 1'b1;
    if (pia_svc_of(take, irq_vec_o, `PIA_VEC_GRP1))
      grp_clr[1] = 1'b1;
    if (pia_svc_of(take, irq_vec_o, `PIA_VEC_GRP2))
      grp_clr[2] = 1'b1;
    if (pia_svc_of(take, irq_vec_o, `PIA_VEC_GRP3))
      grp_clr[3] = 1'b1;
  end

  // ------------------------------------------------------------
  // Flag next values
  // ------------------------------------------------------------
  always @*
  begin
    src_flag_d = (src_flag_o & ~flag_clr_i) | src_set;
    tmr_p_flag_d = (timer_cmp_p_flag_o & ~timer_cmp_p_clr_i) |
                   timer_cmp_p_i;
    tmr_a_flag_d = (timer_cmp_a_flag_o & ~timer_cmp_a_clr_i) |
                   timer_cmp_a_i;
    // group flag auto clear, set wins
    grp_flag_d = (group_req_flag_o & ~grp_clr) | grp_set;
    motor_flag_d = (motor_protect_req_flag_o &
      ~pia_svc_of(take, irq_vec_o, `PIA_VEC_MOTOR)) | motor_protect_trip_i;
    tick_flag_d = (tick_req_flag_o &
      ~pia_svc_of(take, irq_vec_o, `PIA_VEC_TICK)) | tick_pulse;
  end

  // ------------------------------------------------------------
  // Flags and vector request
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      irq_req_o <= 1'b0;
      irq_vec_o <= `PIA_VEC_NONE;
      global_irq_en_o <= 1'b0;
      motor_protect_req_flag_o <= 1'b0;
      group_req_flag_o <= 4'h0;
      src_flag_o <= 11'h000;
      timer_cmp_p_flag_o <= {NUM_TMR{1'b0}};
      timer_cmp_a_flag_o <= {NUM_TMR{1'b0}};
      tick_req_flag_o <= 1'b0;
    end
    else
    begin
      src_flag_o <= src_flag_d;
      timer_cmp_p_flag_o <= tmr_p_flag_d;
      timer_cmp_a_flag_o <= tmr_a_flag_d;
      group_req_flag_o <= grp_flag_d;
      motor_protect_req_flag_o <= motor_flag_d;
      tick_req_flag_o <= tick_flag_d;
      if (take)
        global_irq_en_o <= 1'b0;
      else if (global_irq_en_set_i)
        global_irq_en_o <= 1'b1;
      else if (global_irq_en_clr_i)
        global_irq_en_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          irq_vec_o <= vec_d;
          irq_req_o <= (vec_d != `PIA_VEC_NONE);
          if (vec_d != `PIA_VEC_NONE)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (vec_ack_i)
          begin
            irq_req_o <= 1'b0;
            irq_vec_o <= `PIA_VEC_NONE;
            state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wake on any flag rising
  // ------------------------------------------------------------
  // Next against current: every flag wakes in the cycle it sets
  assign all_now = {motor_protect_req_flag_o, tick_req_flag_o,
                    group_req_flag_o, timer_cmp_p_flag_o,
                    timer_cmp_a_flag_o, src_flag_o};
  assign all_d = {motor_flag_d, tick_flag_d, grp_flag_d, tmr_p_flag_d,
                  tmr_a_flag_d, src_flag_d};

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_o <= 1'b0;
    end
    else
    begin
      wake_o <= |(all_d & ~all_now);
    end
  end
endmodule

/* sim/pia_top_chk.sv */
// Port checker for the interrupt aggregator top.
// Assumes a bind onto pia_top; one clock domain.
`timescale 1ns/100ps
`include "pia_regs.vh"
module pia_top_chk
(
  input wire clk_i, // Clock
  input wire rst_n_i, // Reset
  input wire motor_protect_trip_i, // Trip
  input wire conv_done_i, // Done
  input wire conv_result_valid_i, // Result
  input wire [11:0] conv_result_pair_i, // Value
  input wire [11:0] upper_bound_pair_i, // Upper
  input wire upper_limit_trig_en_i, // Upper trigger
  input wire stack_full_i, // Stack full
  input wire vec_ack_i, // Accept
  input wire [10:0] flag_clr_i, // Clears
  input wire irq_req_o, // Request
  input wire [2:0] irq_vec_o, // Vector
  input wire global_irq_en_o, // Global
  input wire motor_protect_req_flag_o, // Motor flag
  input wire [3:0] group_req_flag_o, // Groups
  input wire [10:0] src_flag_o, // Sources
  input wire tick_req_flag_o, // Tick flag
  input wire wake_o // Wake
);
  wire svc = irq_req_o && vec_ack_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------
  // Properties
  // ----------
  AST_MOTOR_SET: assert property
    (motor_protect_trip_i |=> motor_protect_req_flag_o)
    else $error("motor flag missed a trip");
  AST_VEC_GATE: assert property
    ($rose(irq_req_o) |-> $past(global_irq_en_o) && !$past(stack_full_i))
    else $error("vector raised while blocked");
  AST_SVC_CLR: assert property
    (svc |=> !irq_req_o && !global_irq_en_o)
    else $error("service left request or global enable");
  AST_MOTOR_SVC: assert property
    (svc && irq_vec_o == `PIA_VEC_MOTOR && !motor_protect_trip_i
      |=> !motor_protect_req_flag_o)
    else $error("motor flag kept after service");
  AST_TICK_SVC: assert property
    (svc && irq_vec_o == `PIA_VEC_TICK |=> !tick_req_flag_o)
    else $error("tick flag kept after service");
  AST_VEC_HOLD: assert property
    (irq_req_o && !vec_ack_i |=> irq_req_o && $stable(irq_vec_o))
    else $error("pending vector changed");
  AST_SRC_KEEP: assert property
    (svc && flag_clr_i == 11'h000 |=> ($past(src_flag_o) & ~src_flag_o) == 0)
    else $error("source flag cleared by service");
  AST_GRP2_SET: assert property
    (|(src_flag_o[7:4] & ~$past(src_flag_o[7:4])) |-> group_req_flag_o[2])
    else $error("group flag missed a member");
  AST_LIMIT: assert property
    (conv_result_valid_i && upper_limit_trig_en_i &&
      conv_result_pair_i > upper_bound_pair_i |=> src_flag_o[1])
    else $error("limit flag missed");
  AST_DONE: assert property
    (conv_done_i |=> src_flag_o[0])
    else $error("done flag missed");
  AST_WAKE: assert property
    ($rose(motor_protect_req_flag_o) || $rose(tick_req_flag_o) ||
      (|(src_flag_o & ~$past(src_flag_o))) |-> wake_o)
    else $error("flag rose without wake");
  cover property (svc && irq_vec_o == `PIA_VEC_MOTOR);
  cover property (svc && irq_vec_o == `PIA_VEC_GRP2);
  cover property (svc && irq_vec_o == `PIA_VEC_TICK);
endmodule
bind pia_top pia_top_chk u_chk (.clk_i, .rst_n_i, .motor_protect_trip_i,
  .conv_done_i, .conv_result_valid_i, .conv_result_pair_i,
  .upper_bound_pair_i, .upper_limit_trig_en_i, .stack_full_i, .vec_ack_i,
  .flag_clr_i, .irq_req_o, .irq_vec_o, .global_irq_en_o,
  .motor_protect_req_flag_o, .group_req_flag_o, .src_flag_o,
  .tick_req_flag_o, .wake_o);

/* sim/pia_core_model.sv */
// Core model: accepts each vector request after a set wait.
// Assumes the request level holds until accepted.
`timescale 1ns/100ps
module pia_core_model
(
  input wire clk_i, // Clock
  input wire rst_n_i, // Reset
  input wire irq_req_i, // Vector request
  input wire [3:0] lat_i, // Wait cycles
  output reg vec_ack_o // Accept pulse
);
  reg [3:0] wait_q;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_q <= 4'h0;
      vec_ack_o <= 1'b0;
    end
    else
    begin
      wait_q <= (vec_ack_o || !irq_req_i) ? 4'h0 : wait_q + 4'h1;
      vec_ack_o <= irq_req_i && !vec_ack_o && wait_q >= lat_i;
    end
  end
endmodule

/* sim/pia_top_bench.sv */
// Self-checking bench for the interrupt aggregator top.
// Assumes the core model accepts every vector request.
`timescale 1ns/100ps
`include "pia_regs.vh"
module pia_top_bench;
  logic clk_i, rst_n_i, sub_clk_i, stack_full_i, trip, men, ten, ton, uen;
  logic len;
  logic [11:0] ev, en, clr, res, up, lo;
  logic [1:0] g, src;
  logic [2:0] sel;
  logic [3:0] gen, lat;
  wire vec_ack_i, irq_req_o, global_irq_en_o, motor_protect_req_flag_o;
  wire tick_req_flag_o, wake_o;
  wire [2:0] irq_vec_o;
  wire [3:0] group_req_flag_o;
  wire [10:0] src_flag_o;
  wire [1:0] pf, af;
  wire [11:0] flg = {af, pf, src_flag_o[7:0]};
  wire [2:0] mon = {tick_req_flag_o, global_irq_en_o, irq_req_o};
  integer n_fail = 0, cmp_count = 0, cyc = 0, i, k, t0, span;
  pia_top u_pia_top (.clk_i, .rst_n_i, .motor_protect_trip_i(trip),
    .conv_done_i(ev[0]), .conv_result_valid_i(ev[1]),
    .conv_result_pair_i(res), .upper_bound_pair_i(up),
    .lower_bound_pair_i(lo), .upper_limit_trig_en_i(uen),
    .lower_limit_trig_en_i(len), .capture_overflow_irq_i(ev[2]),
    .capture_compare_irq_i(ev[3]), .period_match_i(ev[4]),
    .duty_match_i(ev[7:5]), .timer_cmp_p_i(ev[9:8]),
    .timer_cmp_a_i(ev[11:10]), .sub_clk_i, .global_irq_en_set_i(g[0]),
    .global_irq_en_clr_i(g[1]), .motor_protect_irq_en_i(men),
    .group_irq_en_i(gen), .conv_done_irq_en_i(en[0]),
    .conv_limit_irq_en_i(en[1]), .capture_overflow_en_i(en[2]),
    .capture_compare_en_i(en[3]), .period_match_irq_en_i(en[4]),
    .duty_match_irq_en_i(en[7:5]), .timer_cmp_p_irq_en_i(en[9:8]),
    .timer_cmp_a_irq_en_i(en[11:10]), .tick_irq_en_i(ten),
    .tick_on_i(ton), .tick_period_sel_i(sel), .prescale_src_sel_i(src),
    .flag_clr_i({3'h0, clr[7:0]}), .timer_cmp_p_clr_i(clr[9:8]),
    .timer_cmp_a_clr_i(clr[11:10]), .stack_full_i, .vec_ack_i, .irq_req_o,
    .irq_vec_o, .global_irq_en_o, .motor_protect_req_flag_o,
    .group_req_flag_o, .src_flag_o, .timer_cmp_p_flag_o(pf),
    .timer_cmp_a_flag_o(af), .tick_req_flag_o, .wake_o);
  pia_core_model u_pia_core_model (.clk_i, .rst_n_i, .irq_req_i(irq_req_o),
    .lat_i(lat), .vec_ack_o(vec_ack_i));
  // ----------
  // Clocks and helpers
  // ----------
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Sub clock of ten system cycles, offset in phase
  initial
  begin
    sub_clk_i = 1'b0;
    #1.3;
    forever #20 sub_clk_i = ~sub_clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  task tally_and_finish;
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wait_for(input integer b, input v, input integer n);
    #1;
    repeat (n) if (mon[b] !== v) step(1);
  endtask
  task pulse(input [11:0] e, input [11:0] c, input [1:0] gg, input t);
    @(posedge clk_i);
    ev <= e;
    clr <= c;
    g <= gg;
    trip <= t;
    @(posedge clk_i);
    ev <= 12'h000;
    clr <= 12'h000;
    g <= 2'h0;
    trip <= 1'b0;
    #1;
  endtask
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    {ev, en, clr, g, trip, men, ten, ton, uen, len, sel, src} = '0;
    {stack_full_i, res, up, lo} = '0;
    gen = 4'hF;
    lat = 4'h2;
    rst_n_i = 1'b0;
    step(15);
    @(posedge clk_i) rst_n_i <= 1'b1;
    step(1);
    chk({irq_req_o, global_irq_en_o}, 0);
    chk({src_flag_o, tick_req_flag_o}, 0);
    // Global enable set and clear pulses
    pulse(0, 0, 2'h1, 1'b0);
    chk(global_irq_en_o, 1);
    pulse(0, 0, 2'h2, 1'b0);
    chk(global_irq_en_o, 0);
    // Motor and duty pending while the stack is full
    @(posedge clk_i) men <= 1'b1;
    en <= 12'h020;
    stack_full_i <= 1'b1;
    pulse(12'h020, 0, 2'h1, 1'b1);
    chk({motor_protect_req_flag_o, wake_o}, 2'h3);
    step(4);
    chk(irq_req_o, 0);
    @(posedge clk_i) stack_full_i <= 1'b0;
    wait_for(0, 1, 10);
    chk(irq_vec_o, `PIA_VEC_MOTOR);
    wait_for(0, 0, 20);
    chk({motor_protect_req_flag_o, mon[1], group_req_flag_o[2]}, 1);
    @(posedge clk_i) men <= 1'b0;
    pulse(0, 0, 2'h1, 1'b1);
    chk(motor_protect_req_flag_o, 1);
    wait_for(0, 1, 10);
    chk(irq_vec_o, `PIA_VEC_GRP2);
    wait_for(0, 0, 20);
    chk(motor_protect_req_flag_o, 1);
    chk({group_req_flag_o[2], src_flag_o[5]}, 2'h1);
    pulse(0, 12'h020, 0, 1'b0);
    // Every grouped source, group enable withheld first
    @(posedge clk_i) res <= 12'h001;
    uen <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      k = (i < 2) ? 0 : (i < 4) ? 1 : (i < 8) ? 2 : 3;
      @(posedge clk_i) en <= 12'h001 << i;
      gen <= ~(4'h1 << k);
      lat <= i[3:0];
      pulse(12'h001 << i, 0, 2'h1, 1'b0);
      chk(flg[i], 1);
      chk(group_req_flag_o[k], 1);
      step(3);
      chk(irq_req_o, 0);
      @(posedge clk_i) gen <= 4'hF;
      wait_for(0, 1, 10);
      chk(irq_vec_o, `PIA_VEC_GRP0 + k);
      wait_for(0, 0, 20);
      chk({flg[i], group_req_flag_o[k], global_irq_en_o}, 4);
      pulse(0, 12'h001 << i, 0, 1'b0);
      chk(flg[i], 0);
    end
    // Limit compare around both boundaries
    @(posedge clk_i) up <= 12'h7FF;
    lo <= 12'h7FF;
    for (k = 0; k < 12; k++)
    begin
      @(posedge clk_i) res <= 12'h7FE + k[1:0];
      {len, uen} <= k[3:2];
      pulse(12'h002, 0, 0, 1'b0);
      chk(src_flag_o[1], (uen && res > up) || (len && res < lo));
      pulse(0, 12'h002, 0, 1'b0);
    end
    // Tick interval per source and period select
    @(posedge clk_i) ten <= 1'b1;
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk_i) src <= {k[1], k[1] | k[0]};
      sel <= {2'h0, k[0]};
      ton <= 1'b1;
      pulse(0, 0, 2'h1, 1'b0);
      wait_for(2, 1, 6000);
      t0 = cyc;
      wait_for(2, 0, 20);
      chk(tick_req_flag_o, 0);
      pulse(0, 0, 2'h1, 1'b0);
      wait_for(2, 1, 6000);
      span = (32'h1 << (8 + sel)) * (src == 0 ? 1 : src == 1 ? 4 : 10);
      chk(cyc - t0, span);
      @(posedge clk_i) ton <= 1'b0;
      wait_for(2, 0, 20);
    end
    tally_and_finish;
  end
endmodule
